// >>> common/srx_pkg.sv
// srx_pkg: register map, field layout and reset values of the receiver and
// oscillator configuration bank. assumes a byte-wide serial configuration port.
package srx_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] OFS_VARACTOR  = 10'h1b5;
  localparam logic [9:0] OFS_AMPLITUDE = 10'h1b6;
  localparam logic [9:0] OFS_BIAS      = 10'h1bb;
  localparam logic [9:0] OFS_CAL_TC    = 10'h1bd;
  localparam logic [9:0] OFS_PLL_FIX   = 10'h1c4;
  localparam logic [9:0] OFS_RECEIVER_MASTER_POWERDOWN = 10'h200;
  localparam logic [9:0] OFS_LANE_PHY_POWERDOWN    = 10'h201;
  localparam logic [9:0] OFS_SYNC_PD   = 10'h203;
  localparam logic [9:0] OFS_CDR_RST   = 10'h206;
  localparam logic [9:0] OFS_CDR_MODE  = 10'h230;
  localparam logic [9:0] OFS_LINK_FIX  = 10'h232;
  localparam logic [9:0] OFS_EQ_BIAS   = 10'h268;

  // ----------------------------------------------------------------------
  // writable-bit masks (zero bits are read-only reserved)
  // ----------------------------------------------------------------------
  localparam logic [7:0] MSK_BIAS     = 8'h1f;
  localparam logic [7:0] MSK_CAL_TC   = 8'h07;
  localparam logic [7:0] MSK_MASTER   = 8'h01;
  localparam logic [7:0] MSK_SYNC     = 8'h03;
  localparam logic [7:0] MSK_CDR_RST  = 8'h01;
  localparam logic [7:0] MSK_CDR_MODE = 8'h3e;
  localparam logic [7:0] MSK_FULL     = 8'hff;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_VARACTOR  = 8'h83;
  localparam logic [7:0] RST_AMPLITUDE = 8'h4a;
  localparam logic [7:0] RST_BIAS      = 8'h0c;
  localparam logic [7:0] RST_CAL_TC    = 8'h00;
  localparam logic [7:0] RST_PLL_FIX   = 8'h33;
  localparam logic [7:0] RST_RECEIVER_MASTER_POWERDOWN = 8'h01;
  localparam logic [7:0] RST_LANE_PHY_POWERDOWN    = 8'h00;
  localparam logic [7:0] RST_SYNC_PD   = 8'h00;
  localparam logic [7:0] RST_CDR_RST   = 8'h01;
  localparam logic [7:0] RST_CDR_MODE  = 8'h28;
  localparam logic [7:0] RST_LINK_FIX  = 8'h00;
  localparam logic [7:0] RST_EQ_BIAS   = 8'h62;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SYNC0_PD   = 1;
  localparam int BIT_SYNC1_PD   = 0;
  localparam int BIT_HALF_RATE  = 5;
  localparam int BIT_OVERSAMPLE = 1;
  localparam int EQ_MSB         = 7;
  localparam int EQ_LSB         = 6;

  typedef enum logic [1:0] {
    SRX_EQ_NORMAL = 2'h0,
    SRX_EQ_LOW    = 2'h1
  } srx_eq_e;

  // configuration request from the serial port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } srx_req_s;

  // analog control outputs
  typedef struct packed {
    logic [3:0] oscillator_varactor_setting;
    logic [3:0] oscillator_amplitude;
    logic [1:0] oscillator_bias_tempco;
    logic [2:0] oscillator_bias_level;
    logic [2:0] band_cal_reference_tempco;
    logic [7:0] pll_fixed_setup;
    logic       receiver_analog_powerdown;
    logic [7:0] per_lane_phy_powerdown;
    logic       sync_out0_buffer_powerdown;
    logic       sync_out1_buffer_powerdown;
    logic       clock_recovery_reset_n;
    logic       half_rate_recovery_enable;
    logic       input_oversample_enable;
    logic [7:0] link_fixed_setup;
    srx_eq_e    equalizer_power_select;
  } srx_ctl_s;

endpackage

// >>> hw/srx_reg8.sv
// srx_reg8: one byte-wide configuration register with a writable-bit mask.
// assumes writes arrive as a one-cycle strobe on sys_clk_i.
`timescale 1ns/10ps
module srx_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // write side
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  // stored value
  output logic      [7:0] value_o
);

  typedef struct packed {
    logic [7:0] val;
  } srx_reg8_state_s;

  srx_reg8_state_s state_q;
  srx_reg8_state_s state_d;

  // read-only bits keep their reset value, so writes to them never land
  always_comb
  begin
    state_d = state_q;
    if (we_i)
    begin
      state_d.val = (wdata_i & WR_MASK) | (state_q.val & ~WR_MASK);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q.val <= RST_VAL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign value_o = state_q.val;

endmodule

// >>> hw/srx_cfg_regs.sv
// srx_cfg_regs: oscillator tuning and receiver front-end configuration bank.
// assumes a serial port front end delivering byte requests on sys_clk_i.
`timescale 1ns/10ps
module srx_cfg_regs
  import srx_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // configuration port
  input  srx_req_s        req_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  // analog controls
  output srx_ctl_s        ctl_o
);

  // ----------------------------------------------------------------------
  // register array
  // ----------------------------------------------------------------------
  localparam int NREG = 12;
  localparam logic [NREG*10-1:0] OFS_TAB = {
    OFS_EQ_BIAS, OFS_LINK_FIX, OFS_CDR_MODE, OFS_CDR_RST, OFS_SYNC_PD, OFS_LANE_PHY_POWERDOWN,
    OFS_RECEIVER_MASTER_POWERDOWN, OFS_PLL_FIX, OFS_CAL_TC, OFS_BIAS, OFS_AMPLITUDE, OFS_VARACTOR};
  localparam logic [NREG*8-1:0] RST_TAB = {
    RST_EQ_BIAS, RST_LINK_FIX, RST_CDR_MODE, RST_CDR_RST, RST_SYNC_PD, RST_LANE_PHY_POWERDOWN,
    RST_RECEIVER_MASTER_POWERDOWN, RST_PLL_FIX, RST_CAL_TC, RST_BIAS, RST_AMPLITUDE, RST_VARACTOR};
  // reserved fields marked read-write keep full masks: software owns them
  localparam logic [NREG*8-1:0] MSK_TAB = {
    MSK_FULL, MSK_FULL, MSK_CDR_MODE, MSK_CDR_RST, MSK_SYNC, MSK_FULL,
    MSK_MASTER, MSK_FULL, MSK_CAL_TC, MSK_BIAS, MSK_FULL, MSK_FULL};

  logic [7:0] regs [NREG];
  logic [NREG-1:0] hit;

  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    assign hit[g] = (req_i.addr == OFS_TAB[g*10 +: 10]);
    srx_reg8 #(
      .RST_VAL (RST_TAB[g*8 +: 8]),
      .WR_MASK (MSK_TAB[g*8 +: 8])
    ) u_reg (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .we_i      (req_i.wr & hit[g]),
      .wdata_i   (req_i.wdata),
      .value_o   (regs[g])
    );
  end

  // ----------------------------------------------------------------------
  // read path and control outputs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    srx_ctl_s   ctl;
  } srx_state_s;

  srx_state_s state_q;
  srx_state_s state_d;
  logic [7:0] rd_mux;

  // unmapped addresses read as zero
  always_comb
  begin
    rd_mux = 8'h00;
    for (int i = 0; i < NREG; i++)
    begin
      if (hit[i])
      begin
        rd_mux = regs[i];
      end
    end
  end

  always_comb
  begin
    state_d        = state_q;
    state_d.rvalid = req_i.rd;
    if (req_i.rd)
    begin
      state_d.rdata = rd_mux;
    end
    state_d.ctl.oscillator_varactor_setting = regs[0][3:0];
    state_d.ctl.oscillator_amplitude        = regs[1][3:0];
    state_d.ctl.oscillator_bias_tempco      = regs[2][4:3];
    state_d.ctl.oscillator_bias_level       = regs[2][2:0];
    state_d.ctl.band_cal_reference_tempco   = regs[3][2:0];
    state_d.ctl.pll_fixed_setup             = regs[4];
    state_d.ctl.receiver_analog_powerdown   = regs[5][0];
    state_d.ctl.per_lane_phy_powerdown      = regs[6];
    state_d.ctl.sync_out0_buffer_powerdown  = regs[7][BIT_SYNC0_PD];
    state_d.ctl.sync_out1_buffer_powerdown  = regs[7][BIT_SYNC1_PD];
    state_d.ctl.clock_recovery_reset_n      = regs[8][0];
    state_d.ctl.half_rate_recovery_enable   = regs[9][BIT_HALF_RATE];
    state_d.ctl.input_oversample_enable     = regs[9][BIT_OVERSAMPLE];
    state_d.ctl.link_fixed_setup            = regs[10];
    state_d.ctl.equalizer_power_select      = srx_eq_e'(regs[11][EQ_MSB:EQ_LSB]);
  end

  // outputs mirror the registers one cycle late; reset values match the bank
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q.rdata                           <= 8'h00;
      state_q.rvalid                          <= 1'b0;
      state_q.ctl.oscillator_varactor_setting <= RST_VARACTOR[3:0];
      state_q.ctl.oscillator_amplitude        <= RST_AMPLITUDE[3:0];
      state_q.ctl.oscillator_bias_tempco      <= RST_BIAS[4:3];
      state_q.ctl.oscillator_bias_level       <= RST_BIAS[2:0];
      state_q.ctl.band_cal_reference_tempco   <= RST_CAL_TC[2:0];
      state_q.ctl.pll_fixed_setup             <= RST_PLL_FIX;
      state_q.ctl.receiver_analog_powerdown   <= RST_RECEIVER_MASTER_POWERDOWN[0];
      state_q.ctl.per_lane_phy_powerdown      <= RST_LANE_PHY_POWERDOWN;
      state_q.ctl.sync_out0_buffer_powerdown  <= RST_SYNC_PD[BIT_SYNC0_PD];
      state_q.ctl.sync_out1_buffer_powerdown  <= RST_SYNC_PD[BIT_SYNC1_PD];
      state_q.ctl.clock_recovery_reset_n      <= RST_CDR_RST[0];
      state_q.ctl.half_rate_recovery_enable   <= RST_CDR_MODE[BIT_HALF_RATE];
      state_q.ctl.input_oversample_enable     <= RST_CDR_MODE[BIT_OVERSAMPLE];
      state_q.ctl.link_fixed_setup            <= RST_LINK_FIX;
      state_q.ctl.equalizer_power_select      <= SRX_EQ_LOW;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rdata_o  = state_q.rdata;
  assign rvalid_o = state_q.rvalid;
  assign ctl_o    = state_q.ctl;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_receiver_master_powerdown;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_RECEIVER_MASTER_POWERDOWN)
      |=> ##1 (ctl_o.receiver_analog_powerdown == $past(req_i.wdata[0], 2));
  endproperty
  a_receiver_master_powerdown : assert property (p_receiver_master_powerdown) else $error("master power-down wrong");

  property p_lane_phy_powerdown;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_LANE_PHY_POWERDOWN)
      |-> ##2 (ctl_o.per_lane_phy_powerdown == $past(req_i.wdata, 2));
  endproperty
  a_lane_phy_powerdown : assert property (p_lane_phy_powerdown) else $error("lane power-down wrong");

  property p_sync_pd;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_SYNC_PD)
      |-> ##2 (ctl_o.sync_out0_buffer_powerdown == $past(req_i.wdata[1], 2)
               && ctl_o.sync_out1_buffer_powerdown == $past(req_i.wdata[0], 2));
  endproperty
  a_sync_pd : assert property (p_sync_pd) else $error("sync buffer power-down wrong");

  property p_cdr_rst;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_CDR_RST && !req_i.wdata[0])
      |-> ##2 !ctl_o.clock_recovery_reset_n;
  endproperty
  a_cdr_rst : assert property (p_cdr_rst) else $error("recovery reset not held");

  property p_eq_sel;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_EQ_BIAS)
      |-> ##2 (ctl_o.equalizer_power_select == $past(req_i.wdata[7:6], 2));
  endproperty
  a_eq_sel : assert property (p_eq_sel) else $error("equalizer select wrong");

  property p_varactor;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_VARACTOR)
      |-> ##2 (ctl_o.oscillator_varactor_setting == $past(req_i.wdata[3:0], 2));
  endproperty
  a_varactor : assert property (p_varactor) else $error("varactor setting wrong");

  property p_amplitude;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_AMPLITUDE)
      |-> ##2 (ctl_o.oscillator_amplitude == $past(req_i.wdata[3:0], 2));
  endproperty
  a_amplitude : assert property (p_amplitude) else $error("amplitude wrong");

  property p_bias;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_BIAS)
      |-> ##2 ({ctl_o.oscillator_bias_tempco, ctl_o.oscillator_bias_level}
               == $past(req_i.wdata[4:0], 2));
  endproperty
  a_bias : assert property (p_bias) else $error("bias fields wrong");

  property p_cal_tc;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.wr && req_i.addr == OFS_CAL_TC)
      |-> ##2 (ctl_o.band_cal_reference_tempco == $past(req_i.wdata[2:0], 2));
  endproperty
  a_cal_tc : assert property (p_cal_tc) else $error("cal tempco wrong");

  property p_ro_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (req_i.rd && !req_i.wr && req_i.addr == OFS_RECEIVER_MASTER_POWERDOWN) |=> (rdata_o[7:1] == 7'h00);
  endproperty
  a_ro_zero : assert property (p_ro_zero) else $error("reserved bits not zero");

endmodule

// >>> bench/srx_host_model.sv
// srx_host_model: host processor on the configuration port of the bank.
// assumes requests are taken on the rising edge of sys_clk_i.
`timescale 1ns/10ps
module srx_host_model
  import srx_pkg::*;
(
  // clock
  input  wire logic       sys_clk_i,
  // answer side
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // request side
  output srx_req_s        req_o
);
  initial req_o = '0;

  // strobe stands for exactly one taking edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    // positional fill: member keys would collide with the task names wr and rd
    req_o = {1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    #1;
    req_o.wr = 1'b0;
  endtask

  // answer is awaited for a bounded number of edges only
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk_i);
    #1;
    req_o = {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    #1;
    req_o.rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    repeat (3)
    begin
      if (!ok && rvalid_i === 1'b1)
      begin
        d = rdata_i;
        ok = 1'b1;
      end
      else if (!ok)
      begin
        @(posedge sys_clk_i);
        #1;
      end
    end
  endtask
endmodule

// >>> bench/srx_cfg_regs_tb_top.sv
// srx_cfg_regs_tb_top: self-checking bench of the configuration bank.
// assumes srx_host_model drives the port; expectations come from a byte model.
`timescale 1ns/10ps
module srx_cfg_regs_tb_top
  import srx_pkg::*;
;
  logic       sys_clk_i;
  logic       rst_i;
  srx_req_s   req;
  logic [7:0] rdata;
  logic       rvalid;
  srx_ctl_s   ctl;
  int         n_fail;
  int         checks;
  int         cyc;
  int         k;
  logic [7:0] mdl [logic [9:0]];
  localparam logic [9:0] OFS [12] = '{OFS_VARACTOR, OFS_AMPLITUDE, OFS_BIAS, OFS_CAL_TC,
    OFS_PLL_FIX, OFS_RECEIVER_MASTER_POWERDOWN, OFS_LANE_PHY_POWERDOWN, OFS_SYNC_PD, OFS_CDR_RST, OFS_CDR_MODE,
    OFS_LINK_FIX, OFS_EQ_BIAS};
  localparam logic [7:0] RSTV [12] = '{RST_VARACTOR, RST_AMPLITUDE, RST_BIAS, RST_CAL_TC,
    RST_PLL_FIX, RST_RECEIVER_MASTER_POWERDOWN, RST_LANE_PHY_POWERDOWN, RST_SYNC_PD, RST_CDR_RST, RST_CDR_MODE,
    RST_LINK_FIX, RST_EQ_BIAS};

  srx_cfg_regs srx_cfg_regs_inst (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .req_i     (req),
    .rdata_o   (rdata),
    .rvalid_o  (rvalid),
    .ctl_o     (ctl)
  );
  srx_host_model srx_host_model_inst (
    .sys_clk_i (sys_clk_i),
    .rdata_i   (rdata),
    .rvalid_i  (rvalid),
    .req_o     (req)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] msk(input logic [9:0] a);
    case (a)
      OFS_BIAS:      return MSK_BIAS;
      OFS_CAL_TC:    return MSK_CAL_TC;
      OFS_RECEIVER_MASTER_POWERDOWN: return MSK_MASTER;
      OFS_SYNC_PD:   return MSK_SYNC;
      OFS_CDR_RST:   return MSK_CDR_RST;
      OFS_CDR_MODE:  return MSK_CDR_MODE;
      default:       return MSK_FULL;
    endcase
  endfunction

  function automatic srx_ctl_s ctl_exp();
    srx_ctl_s c;
    c.oscillator_varactor_setting = mdl[OFS_VARACTOR][3:0];
    c.oscillator_amplitude        = mdl[OFS_AMPLITUDE][3:0];
    c.oscillator_bias_tempco      = mdl[OFS_BIAS][4:3];
    c.oscillator_bias_level       = mdl[OFS_BIAS][2:0];
    c.band_cal_reference_tempco   = mdl[OFS_CAL_TC][2:0];
    c.pll_fixed_setup             = mdl[OFS_PLL_FIX];
    c.receiver_analog_powerdown   = mdl[OFS_RECEIVER_MASTER_POWERDOWN][0];
    c.per_lane_phy_powerdown      = mdl[OFS_LANE_PHY_POWERDOWN];
    c.sync_out0_buffer_powerdown  = mdl[OFS_SYNC_PD][BIT_SYNC0_PD];
    c.sync_out1_buffer_powerdown  = mdl[OFS_SYNC_PD][BIT_SYNC1_PD];
    c.clock_recovery_reset_n      = mdl[OFS_CDR_RST][0];
    c.half_rate_recovery_enable   = mdl[OFS_CDR_MODE][5];
    c.input_oversample_enable     = mdl[OFS_CDR_MODE][1];
    c.link_fixed_setup            = mdl[OFS_LINK_FIX];
    c.equalizer_power_select      = srx_eq_e'(mdl[OFS_EQ_BIAS][7:6]);
    return c;
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // register access through the host
  // ----------------------------------------------------------------------
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    srx_host_model_inst.wr(a, d);
    if (mdl.exists(a))
      mdl[a] = d & msk(a);
    @(posedge sys_clk_i);
    #1;
    chk(ctl, ctl_exp(), "controls");
  endtask

  task automatic rreg(input logic [9:0] a);
    logic [7:0] d;
    logic       ok;
    srx_host_model_inst.rd(a, d, ok);
    chk(48'(ok), 48'h1, "no read answer");
    chk(48'(d), 48'(mdl.exists(a) ? mdl[a] : 8'h00), "read data");
    // the answer pulse must not stand past its single cycle
    @(posedge sys_clk_i);
    #1;
    chk(48'(rvalid), 48'h0, "read answer stood too long");
  endtask

  task automatic load_reset();
    foreach (OFS[i])
      mdl[OFS[i]] = RSTV[i];
  endtask

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    void'($urandom(3));
    load_reset();
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk(ctl, ctl_exp(), "reset controls");
    foreach (OFS[i])
      rreg(OFS[i]);
    $display("test reset values done");
    // all ones then all zeros expose read-only reserved bits
    foreach (OFS[i])
    begin
      wreg(OFS[i], 8'hff);
      rreg(OFS[i]);
      wreg(OFS[i], 8'h00);
      rreg(OFS[i]);
    end
    wreg(10'h1b7, 8'ha5);
    rreg(10'h1b7);
    rreg(10'h3ff);
    $display("test access kinds done");
    for (k = 0; k < 8; k++)
      wreg(OFS_LANE_PHY_POWERDOWN, 8'h01 << k);
    wreg(OFS_SYNC_PD, 8'h02);
    wreg(OFS_SYNC_PD, 8'h01);
    for (k = 0; k < 4; k++)
      wreg(OFS_EQ_BIAS, {k[1:0], 6'h22});
    $display("test field mapping done");
    repeat (60)
    begin
      k = $urandom_range(11, 0);
      wreg(OFS[k], 8'($urandom));
      if ($urandom_range(1, 0) == 1)
        rreg(OFS[k]);
    end
    $display("test random access done");
    wreg(OFS_VARACTOR, 8'h85);
    rreg(OFS_VARACTOR);
    wreg(OFS_PLL_FIX, 8'h73);
    wreg(OFS_LINK_FIX, 8'hff);
    wreg(OFS_CDR_MODE, 8'h28);
    wreg(OFS_CDR_MODE, 8'h0a);
    wreg(OFS_CDR_RST, 8'h01);
    wreg(OFS_RECEIVER_MASTER_POWERDOWN, 8'h00);
    rreg(OFS_CDR_MODE);
    @(posedge sys_clk_i);
    #1;
    rst_i = 1'b1;
    load_reset();
    #2;
    chk(ctl, ctl_exp(), "second reset controls");
    @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    rreg(OFS_PLL_FIX);
    $display("test bring-up and second reset done");
    test_done();
  end
endmodule
